// ===== rtl/eep_target.sv
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`include "eep_params.svh"
module eep_target
  import eep_pkg::*;
#(
  parameter int unsigned READY_CYC = `EEP_READY_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  eep_bus_if.tgt bus,
  input wire logic strap_bit_low,
  input wire logic strap_bit_mid,
  input wire logic strap_bit_high,
  input wire logic wp,
  input wire logic [7:0] rd_data,
  output logic ready,
  output logic selected,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rd_taken
);
  localparam int FILT_CYC = (`EEP_GLITCH_NS + `EEP_CLK_PERIOD_NS - 1) / `EEP_CLK_PERIOD_NS;
  localparam int RW = $clog2(READY_CYC + 1);

  if (READY_CYC < 2 || FILT_CYC > 30) begin : g_bad_param
    $error("eep_target: unsupported ready or filter count");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] flt;
    logic [1:0][4:0] fcnt;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic wp_s1;
    logic wp_s2;
    logic [RW-1:0] rcnt;
    logic ready;
    eep_tgt_state_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic mack;
    logic oe;
    logic sel;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rd_taken;
  } eep_tgt_s;

  eep_tgt_s q;
  eep_tgt_s n;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  // Next-state logic; index 0 of the line vectors is the clock, 1 the data
  always_comb begin
    n = q;
    n.rx_valid = 1'b0;
    n.rd_taken = 1'b0;
    // Pins pass two flops before anything looks at them
    n.s1 = {bus.sda, bus.scl};
    n.s2 = q.s1;
    n.strap_s1 = {strap_bit_high, strap_bit_mid, strap_bit_low};
    n.strap_s2 = q.strap_s1;
    n.wp_s1 = wp;
    n.wp_s2 = q.wp_s1;
    // glitch filter
    // A change is taken only after it has stood longer than the glitch window
    for (int i = 0; i < 2; i++) begin
      if (q.s2[i] == q.flt[i]) begin
        n.fcnt[i] = 5'h00;
      end else if (q.fcnt[i] == 5'(FILT_CYC)) begin
        n.flt[i] = q.s2[i];
        n.fcnt[i] = 5'h00;
      end else begin
        n.fcnt[i] = q.fcnt[i] + 5'h01;
      end
    end
    if (!q.ready) begin
      if (q.rcnt == RW'(READY_CYC - 1)) begin
        n.ready = 1'b1;
      end else begin
        n.rcnt = q.rcnt + RW'(1);
      end
    end
    scl_rise = ~q.flt[0] & n.flt[0];
    scl_fall = q.flt[0] & ~n.flt[0];
    start_ev = q.ready & q.flt[0] & n.flt[0] & q.flt[1] & ~n.flt[1];
    stop_ev = q.ready & q.flt[0] & n.flt[0] & ~q.flt[1] & n.flt[1];
    case (q.st)
      T_IDLE: begin
        n.oe = 1'b0;
      end
      T_ADDR: begin
        if (scl_rise) begin
          n.sh = {q.sh[6:0], n.flt[1]};
          n.cnt = q.cnt + 4'h1;
        end
        if (scl_fall && q.cnt == 4'h8) begin
          if (q.sh[7:4] == `EEP_TYPE_CODE && q.sh[3:1] == q.strap_s2) begin
            n.oe = 1'b1;
            n.rw = q.sh[0];
            n.sel = 1'b1;
            n.st = T_ACK_ADDR;
          end else begin
            n.st = T_IDLE;
          end
        end
      end
      T_ACK_ADDR: begin
        if (scl_fall) begin
          n.cnt = 4'h0;
          if (q.rw) begin
            n.sh = rd_data;
            n.oe = ~rd_data[7];
            n.rd_taken = 1'b1;
            n.st = T_TX;
          end else begin
            n.oe = 1'b0;
            n.st = T_RX;
          end
        end
      end
      T_RX: begin
        if (scl_rise) begin
          n.sh = {q.sh[6:0], n.flt[1]};
          n.cnt = q.cnt + 4'h1;
        end
        if (scl_fall && q.cnt == 4'h8) begin
          // protected write is nacked
          // Write protect is strobed at the fall before the ninth clock
          if (!q.wp_s2) begin
            n.oe = 1'b1;
            n.rx_data = q.sh;
            n.rx_valid = 1'b1;
          end
          n.st = T_ACK_RX;
        end
      end
      T_ACK_RX: begin
        if (scl_fall) begin
          n.oe = 1'b0;
          n.cnt = 4'h0;
          // A refused write is dropped until the next start
          n.st = q.oe ? T_RX : T_WAIT;
        end
      end
      T_TX: begin
        if (scl_rise) begin
          n.cnt = q.cnt + 4'h1;
        end
        if (scl_fall) begin
          if (q.cnt == 4'h8) begin
            n.oe = 1'b0;
            n.st = T_ACK_TX;
          end else begin
            n.sh = {q.sh[6:0], 1'b0};
            n.oe = ~q.sh[6];
          end
        end
      end
      T_ACK_TX: begin
        if (scl_rise) begin
          n.mack = ~n.flt[1];
        end
        if (scl_fall) begin
          n.cnt = 4'h0;
          if (q.mack) begin
            n.sh = rd_data;
            n.oe = ~rd_data[7];
            n.rd_taken = 1'b1;
            n.st = T_TX;
          end else begin
            n.st = T_WAIT;
          end
        end
      end
      T_WAIT: begin
        n.oe = 1'b0;
      end
      default: begin
        n.st = T_IDLE;
        n.oe = 1'b0;
      end
    endcase
    if (stop_ev) begin
      n.st = T_IDLE;
      n.oe = 1'b0;
      n.sel = 1'b0;
    end
    if (start_ev) begin
      n.st = T_ADDR;
      n.cnt = 4'h0;
      n.oe = 1'b0;
      n.sel = 1'b0;
    end
    if (!q.ready) begin
      n.st = T_IDLE;
      n.oe = 1'b0;
    end
  end

  // reset state under POR
  // The filtered lines reset high so an idle bus shows no false edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.s1 <= 2'h3;
      q.s2 <= 2'h3;
      q.flt <= 2'h3;
      q.st <= T_IDLE;
    end else begin
      q <= n;
    end
  end

  assign bus.tgt_sda_o = 1'b0;
  assign bus.tgt_sda_oe = q.oe;
  assign ready = q.ready;
  assign selected = q.sel;
  assign rx_data = q.rx_data;
  assign rx_valid = q.rx_valid;
  assign rd_taken = q.rd_taken;
endmodule : eep_target

// ===== rtl/eep_params.svh
`ifndef EEP_PARAMS_SVH
`define EEP_PARAMS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define EEP_CLK_PERIOD_NS 5
`define EEP_GLITCH_NS 100
`define EEP_READY_MS 1
`define EEP_READY_CYC ((`EEP_READY_MS * 1000000) / `EEP_CLK_PERIOD_NS)
`define EEP_QTR_DEF 16'h007D
`define EEP_QTR_MIN 16'h0020
// ----------------------------------------
// Target address
// ----------------------------------------
`define EEP_TYPE_CODE 4'hA
// ----------------------------------------
// Controller register map
// ----------------------------------------
`define EEP_REG_CMD 12'h000
`define EEP_REG_STAT 12'h004
`define EEP_REG_DIV 12'h008
`define EEP_CMD_START 8
`define EEP_CMD_STOP 9
`define EEP_CMD_READ 10
`define EEP_CMD_NACK 11
`define EEP_STAT_BUSY 8
`define EEP_STAT_NACK 9
`define EEP_RESP_OKAY 2'h0
`define EEP_RESP_SLVERR 2'h2
`endif

// ===== rtl/eep_pkg.sv
package eep_pkg;
  // Target sequencer states
  typedef enum logic [2:0] {
    T_IDLE, T_ADDR, T_ACK_ADDR, T_RX, T_ACK_RX, T_TX, T_ACK_TX, T_WAIT
  } eep_tgt_state_e;
  // Controller bit engine states
  typedef enum logic [1:0] {C_IDLE, C_START, C_BIT, C_STOP} eep_ctl_state_e;
endpackage : eep_pkg

// ===== rtl/eep_bus_if.sv
// ----------------------------------------
// Two-wire bus with pull-up resolution
// ----------------------------------------
interface eep_bus_if;
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic tgt_sda_o;
  logic tgt_sda_oe;
  logic scl;
  logic sda;
  // Wired-AND: a line is low only while some party pulls it
  assign scl = ~(ctl_scl_oe & ~ctl_scl_o);
  assign sda = ~((ctl_sda_oe & ~ctl_sda_o) | (tgt_sda_oe & ~tgt_sda_o));
  modport ctl (output ctl_scl_o, output ctl_scl_oe, output ctl_sda_o, output ctl_sda_oe,
               input scl, input sda);
  modport tgt (output tgt_sda_o, output tgt_sda_oe, input scl, input sda);
endinterface : eep_bus_if

// ===== rtl/eep_ctrl.sv
`include "eep_params.svh"
module eep_ctrl
  import eep_pkg::*;
#(
  parameter int unsigned AW = 12,
  parameter logic [15:0] QTR_RESET = `EEP_QTR_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  eep_bus_if.ctl bus,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  if (AW < 4 || QTR_RESET < `EEP_QTR_MIN) begin : g_bad_param
    $error("eep_ctrl: address too narrow or quarter period too short");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [AW-1:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] qtr;
    logic [11:0] cmd;
    logic busy;
    logic nack;
    logic [7:0] rxb;
    eep_ctl_state_e st;
    logic [1:0] ph;
    logic [15:0] tcnt;
    logic [3:0] bitn;
    logic [7:0] txsh;
    logic scl_oe;
    logic sda_oe;
    logic [1:0] sda_s;
  } eep_ctl_s;

  eep_ctl_s q;
  eep_ctl_s n;
  logic [31:0] wmask;
  logic [31:0] wnew;
  logic tick;

  always_comb begin
    n = q;
    wmask = {{8{q.ws[3]}}, {8{q.ws[2]}}, {8{q.ws[1]}}, {8{q.ws[0]}}};
    wnew = 32'h00000000;
    n.sda_s = {q.sda_s[0], bus.sda};
    // ----------------------------------------
    // AXI4-Lite write: address and data in either order
    // ----------------------------------------
    if (s_axi_awvalid && q.awready) begin
      n.aw_got = 1'b1;
      n.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_got = 1'b1;
      n.wd = s_axi_wdata;
      n.ws = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `EEP_RESP_OKAY;
      case ({q.awa[AW-1:2], 2'h0})
        AW'(`EEP_REG_CMD): begin
          wnew = ({20'h00000, q.cmd} & ~wmask) | (q.wd & wmask);
          // begin only on idle bus
          // A command while busy is refused so the bus is never interrupted
          if (q.busy) begin
            n.bresp = `EEP_RESP_SLVERR;
          end else begin
            n.cmd = wnew[11:0];
            n.busy = 1'b1;
            n.nack = 1'b0;
            n.txsh = wnew[7:0];
            n.ph = 2'h0;
            n.tcnt = 16'h0000;
            n.bitn = 4'h0;
            n.st = wnew[`EEP_CMD_START] ? C_START : C_BIT;
          end
        end
        AW'(`EEP_REG_DIV): begin
          wnew = ({16'h0000, q.qtr} & ~wmask) | (q.wd & wmask);
          // Too short a phase would fall inside the target's glitch window
          n.qtr = (wnew[15:0] < `EEP_QTR_MIN) ? `EEP_QTR_MIN : wnew[15:0];
        end
        AW'(`EEP_REG_STAT): begin
          n.bresp = `EEP_RESP_OKAY;
        end
        default: begin
          n.bresp = `EEP_RESP_SLVERR;
        end
      endcase
    end
    // ----------------------------------------
    // AXI4-Lite read
    // ----------------------------------------
    if (s_axi_rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = `EEP_RESP_OKAY;
      n.rdata = 32'h00000000;
      case ({s_axi_araddr[AW-1:2], 2'h0})
        AW'(`EEP_REG_CMD): n.rdata[11:0] = q.cmd;
        AW'(`EEP_REG_STAT): n.rdata[9:0] = {q.nack, q.busy, q.rxb};
        AW'(`EEP_REG_DIV): n.rdata[15:0] = q.qtr;
        default: n.rresp = `EEP_RESP_SLVERR;
      endcase
    end
    // ----------------------------------------
    // Bus engine: four quarter phases per bit
    // ----------------------------------------
    // controller owns the clock
    tick = (q.st != C_IDLE) && (q.tcnt == q.qtr - 16'h0001);
    if (q.st != C_IDLE) begin
      n.tcnt = tick ? 16'h0000 : q.tcnt + 16'h0001;
    end
    if (tick) begin
      n.ph = q.ph + 2'h1;
      case (q.st)
        C_START: begin
          case (q.ph)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b1;
            default: begin
              n.scl_oe = 1'b1;
              n.st = C_BIT;
            end
          endcase
        end
        C_BIT: begin
          case (q.ph)
            2'h0: begin
              if (q.bitn != 4'h8) begin
                n.sda_oe = ~q.cmd[`EEP_CMD_READ] & ~q.txsh[7];
              end else begin
                n.sda_oe = q.cmd[`EEP_CMD_READ] & ~q.cmd[`EEP_CMD_NACK];
              end
            end
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.scl_oe = 1'b0;
            default: begin
              n.scl_oe = 1'b1;
              n.bitn = q.bitn + 4'h1;
              n.txsh = {q.txsh[6:0], 1'b0};
              if (q.bitn != 4'h8) begin
                n.rxb = q.cmd[`EEP_CMD_READ] ? {q.rxb[6:0], q.sda_s[1]} : q.rxb;
              end else begin
                n.nack = ~q.cmd[`EEP_CMD_READ] & q.sda_s[1];
                n.st = q.cmd[`EEP_CMD_STOP] ? C_STOP : C_IDLE;
                n.busy = q.cmd[`EEP_CMD_STOP];
              end
            end
          endcase
        end
        C_STOP: begin
          case (q.ph)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b0;
            default: begin
              n.st = C_IDLE;
              n.busy = 1'b0;
            end
          endcase
        end
        default: n.st = C_IDLE;
      endcase
    end
    n.awready = ~n.aw_got & ~n.bvalid;
    n.wready = ~n.w_got & ~n.bvalid;
    n.arready = ~n.rvalid;
  end

  // Single register stage for all controller state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.qtr <= QTR_RESET;
      q.sda_s <= 2'h3;
      q.st <= C_IDLE;
    end else begin
      q <= n;
    end
  end

  assign bus.ctl_scl_o = 1'b0;
  assign bus.ctl_sda_o = 1'b0;
  assign bus.ctl_scl_oe = q.scl_oe;
  assign bus.ctl_sda_oe = q.sda_oe;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
endmodule : eep_ctrl

// ===== verif/eep_chk.sv
module eep_chk #(
  parameter int unsigned READY_CYC = 50
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ctl_scl_o,
  input wire logic ctl_scl_oe,
  input wire logic ctl_sda_o,
  input wire logic ctl_sda_oe,
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rc_q;
  logic [7:0] lc_q;
  logic [3:0] bit_q;
  logic first_q, scl_q, sda_q;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----
  // Bus trackers
  // ----
  // Cycles since reset, clock low time, clock pulse number within each nine-pulse frame after a start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_q <= 32'h0;
      lc_q <= 8'h00;
      bit_q <= 4'h0;
      first_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (rc_q < READY_CYC) rc_q <= rc_q + 32'h1;
      // Saturates so a long-held low clock cannot wrap back to a short count
      lc_q <= scl ? 8'h00 : ((lc_q == 8'hFF) ? lc_q : lc_q + 8'h01);
      if (scl && scl_q && sda_q && !sda) begin
        bit_q <= 4'h0;
        first_q <= 1'b1;
      end else if (scl && !scl_q) begin
        bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
        if (bit_q == 4'h9) first_q <= 1'b0;
      end
    end
  end
  // ----
  // Properties
  // ----
  a_tgt_open_drain: assert property (tgt_sda_o == 1'b0)
    else $error("target data level not zero");
  a_ctl_open_drain: assert property (!ctl_sda_o && !ctl_scl_o)
    else $error("controller line level not zero");
  a_silent_before_ready: assert property (rc_q < READY_CYC |-> !tgt_sda_oe)
    else $error("target drove data before ready");
  a_stable_clock_high: assert property (scl && scl_q |-> $stable(tgt_sda_oe))
    else $error("target data moved while clock high");
  a_filtered_response: assert property ($changed(tgt_sda_oe) |-> lc_q >= 8'h10)
    else $error("target data moved too soon after clock fall");
  a_start_hold: assert property (scl && $fell(sda) |-> scl [*8])
    else $error("clock fell right after start");
  a_stop_idle: assert property (scl && $rose(sda) |-> ##1 (scl && sda) [*8])
    else $error("bus not idle after stop");
  a_addr_silent: assert property (first_q && scl && scl_q && bit_q != 4'h9 |-> !tgt_sda_oe)
    else $error("target drove data during address bits");
  a_ninth_release: assert property (first_q && scl && scl_q && bit_q == 4'h9 |-> !ctl_sda_oe)
    else $error("controller held data on ninth clock");
endmodule : eep_chk

// ===== verif/testbench.sv
`include "eep_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned READY = 3000;
  localparam logic [7:0] ADDR_W = 8'hAA;
  logic aclk, aresetn, wp, ready, selected, rx_valid, rd_taken, s;
  logic strap_bit_low, strap_bit_mid, strap_bit_high;
  logic [7:0] rd_data, rx_data;
  logic [7:0] masks [5] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h80};
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, st;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_mismatch, num_checks, cyc, rxv_n, rdt_n, k;
  eep_bus_if bus ();
  eep_bus_if b2 ();
  eep_ctrl eep_ctrl_i (.aclk, .aresetn, .bus(bus), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  eep_target #(.READY_CYC(READY)) eep_target_i (.aclk, .aresetn, .bus(bus), .strap_bit_low,
    .strap_bit_mid, .strap_bit_high, .wp, .rd_data, .ready, .selected, .rx_data, .rx_valid,
    .rd_taken);
  // Second target on a bus driven by the bench, for line faults
  eep_target #(.READY_CYC(READY)) eep_target_i2 (.aclk, .aresetn, .bus(b2), .strap_bit_low,
    .strap_bit_mid, .strap_bit_high, .wp, .rd_data, .ready(), .selected(), .rx_data(),
    .rx_valid(), .rd_taken());
  eep_chk #(.READY_CYC(READY)) eep_chk_i (.aclk, .aresetn, .ctl_scl_o(bus.ctl_scl_o),
    .ctl_scl_oe(bus.ctl_scl_oe), .ctl_sda_o(bus.ctl_sda_o), .ctl_sda_oe(bus.ctl_sda_oe),
    .tgt_sda_o(bus.tgt_sda_o), .tgt_sda_oe(bus.tgt_sda_oe), .scl(bus.scl), .sda(bus.sda));
  // Clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Pulse counters and hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1) rxv_n <= rxv_n + 1;
    if (rd_taken === 1'b1) rdt_n <= rdt_n + 1;
    if (cyc == 60000) begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Starts one edge late so back-to-back calls never reassign a signal in one step
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rr);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Each channel drops valid at its own handshake; every edge is watched for bvalid
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rr);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // Polls status until the bus engine is idle again
  task automatic wait_idle(output logic [31:0] sv);
    logic [1:0] rr;
    sv = 32'h100;
    while (sv[`EEP_STAT_BUSY]) axi_rd(`EEP_REG_STAT, sv, rr);
  endtask : wait_idle
  task automatic run(input logic [31:0] c, output logic [31:0] sv);
    logic [1:0] rr;
    axi_wr(`EEP_REG_CMD, c, rr);
    chk(32'(rr), 32'(`EEP_RESP_OKAY));
    wait_idle(sv);
  endtask : run
  // One bit on the second bus; returns the data level seen while clock is high
  task automatic bb(input logic b, output logic sv);
    b2.ctl_scl_oe <= 1'b1;
    repeat (40) @(posedge aclk);
    b2.ctl_sda_oe <= ~b;
    repeat (40) @(posedge aclk);
    b2.ctl_scl_oe <= 1'b0;
    repeat (40) @(posedge aclk);
    sv = b2.sda;
    repeat (40) @(posedge aclk);
  endtask : bb
  task automatic send2(input logic [7:0] a, output logic ack);
    for (int i = 7; i >= 0; i--) bb(a[i], ack);
    bb(1'b1, ack);
  endtask : send2
  task final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    aresetn = 1'b0;
    wp = 1'b0;
    {strap_bit_high, strap_bit_mid, strap_bit_low} = 3'b101;
    rd_data = 8'hC3;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {b2.ctl_scl_o, b2.ctl_sda_o, b2.ctl_scl_oe, b2.ctl_sda_oe} = 4'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // A too short quarter is clamped; strobes keep unselected bytes
    axi_wr(`EEP_REG_DIV, 32'h10, r);
    axi_rd(`EEP_REG_DIV, st, r);
    chk(st, 32'h20);
    s_axi_wstrb <= 4'h1;
    axi_wr(`EEP_REG_DIV, 32'hFF40, r);
    axi_rd(`EEP_REG_DIV, st, r);
    chk(st, 32'h40);
    s_axi_wstrb <= 4'hF;
    axi_wr(`EEP_REG_DIV, 32'h20, r);
    axi_rd(12'h00C, st, r);
    chk(32'(r), 32'(`EEP_RESP_SLVERR));
    chk(st, 32'h0);
    // Address sent before ready; a second command while busy is refused
    axi_wr(`EEP_REG_CMD, 32'h3AA, r);
    chk(32'(r), 32'(`EEP_RESP_OKAY));
    axi_wr(`EEP_REG_CMD, 32'h1AB, r);
    chk(32'(r), 32'(`EEP_RESP_SLVERR));
    axi_rd(`EEP_REG_CMD, st, r);
    chk(st, 32'h3AA);
    wait_idle(st);
    chk(32'(st[`EEP_STAT_NACK]), 1);
    chk(32'(ready), 0);
    k = 0;
    while (ready !== 1'b1 && k < READY) begin
      @(posedge aclk);
      k++;
    end
    chk(32'(ready), 1);
    // Every wrong strap bit, and a wrong lowest or highest type bit, goes unanswered
    foreach (masks[i]) begin
      run(32'h300 | 32'(ADDR_W ^ masks[i]), st);
      chk(32'(st[`EEP_STAT_NACK]), 1);
    end
    // Matched write, one data byte, then stop
    run(32'h1AA, st);
    chk(32'(st[`EEP_STAT_NACK]), 0);
    chk(32'(selected), 1);
    k = rxv_n;
    run(32'h25A, st);
    chk(32'(st[`EEP_STAT_NACK]), 0);
    chk(32'(rx_data), 32'h5A);
    chk(32'(rxv_n - k), 1);
    chk(32'(selected), 0);
    // Read two bytes, acknowledging the first
    k = rdt_n;
    run(32'h1AB, st);
    chk(32'(st[`EEP_STAT_NACK]), 0);
    run(32'h400, st);
    chk(32'(st[7:0]), 32'hC3);
    run(32'hE00, st);
    chk(32'(st[7:0]), 32'hC3);
    chk(32'(rdt_n - k), 2);
    // Protected write: address answered, data byte refused
    wp <= 1'b1;
    run(32'h1AA, st);
    chk(32'(st[`EEP_STAT_NACK]), 0);
    k = rxv_n;
    run(32'h266, st);
    chk(32'(st[`EEP_STAT_NACK]), 1);
    chk(32'(rxv_n - k), 0);
    wp <= 1'b0;
    // A 100 ns dip is no start; a longer one is
    b2.ctl_sda_oe <= 1'b1;
    repeat (20) @(posedge aclk);
    b2.ctl_sda_oe <= 1'b0;
    repeat (40) @(posedge aclk);
    send2(ADDR_W, s);
    chk(32'(s), 1);
    b2.ctl_sda_oe <= 1'b1;
    repeat (40) @(posedge aclk);
    send2(ADDR_W, s);
    chk(32'(s), 0);
    // Mid-run power loss: the acking target lets go of the line at once
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(ready), 0);
    chk(32'(b2.sda), 1);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(32'(ready), 0);
    final_report();
  end
endmodule : testbench
